// file: logic/cal_pkg.sv
// Package for the arithmetic and logic datapath subset.
// Assumes: consumed by cal_core and by the register-bus testbench.
package cal_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] CAL_OFF_CMD = 8'h00;
  localparam logic [7:0] CAL_OFF_ACC = 8'h04;
  localparam logic [7:0] CAL_OFF_STAT = 8'h08;
  localparam logic [7:0] CAL_OFF_PTR0 = 8'h0C;
  localparam logic [7:0] CAL_OFF_PTR1 = 8'h10;
  localparam logic [7:0] CAL_OFF_FILE = 8'h14;
  // Command word fields
  localparam int CAL_OP_LSB = 0;
  localparam int CAL_IMM_LSB = 8;
  localparam int CAL_ADDR_LSB = 16;
  localparam int CAL_DEST_BIT = 23;
  localparam int CAL_PSEL_BIT = 24;
  // File window fields: write data in low byte, file address above
  localparam int CAL_FADDR_LSB = 8;
  // Status bit positions
  localparam int CAL_ST_C = 0;
  localparam int CAL_ST_NIB = 1;
  localparam int CAL_ST_Z = 2;
  // Sizes and reset values
  localparam int CAL_FILE_DEPTH = 128;
  localparam logic [7:0] CAL_ACC_RST = 8'h00;
  localparam logic [15:0] CAL_PTR_RST = 16'h0000;
  localparam logic [1:0] CAL_RESP_OKAY = 2'b00;
  localparam logic [1:0] CAL_RESP_SLVERR = 2'b10;
  // Operation codes
  typedef enum logic [2:0] {
    CAL_OP_NONE = 3'h0,
    CAL_OP_PTR_ADD = 3'h1,
    CAL_OP_AND_IMM = 3'h2,
    CAL_OP_ADD_IMM = 3'h3,
    CAL_OP_AND_REG = 3'h4,
    CAL_OP_ADD_REG = 3'h5,
    CAL_OP_ASR = 3'h6,
    CAL_OP_ADDC_REG = 3'h7
  } cal_op_t;
endpackage

// file: logic/cal_core.sv
// Arithmetic/logic datapath with accumulator, flags, two pointer pairs, file registers.
// Assumes: single 25 MHz clock, AXI4-Lite master, one write and one read at a time.
//
// Behaviour
// - Pointer add sign-extends 6-bit immediate, no flags
// - Pointer result wraps modulo 2^16
// - AND immediate into accumulator, zero flag only
// - Add immediate into accumulator, carry nibble zero
// - AND accumulator with file register, zero only
// - Target bit 0 accumulator, 1 file register
// - Add accumulator and register, routed, carry nibble zero
// - Arithmetic shift right, keep bit7, C Z
// - Add with carry, routed, carry nibble zero
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module cal_core (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] acc_out,
  output logic [2:0] flags_out
);
  logic rst_meta_q, rstn_q;
  // A channel stays pending while its ready is low
  wire aw_pend = !s_axi_awready;
  wire w_pend = !s_axi_wready;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [7:0] acc_q, acc_d;
  logic c_q, nib_q, z_q, c_d, nib_d, z_d;
  logic [15:0] ptr_q [2];
  logic [7:0] file_q [cal_pkg::CAL_FILE_DEPTH];

  // Reset release through two flops
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      rstn_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rstn_q <= rst_meta_q;
    end
  end

  // Write channel capture and decode
  wire do_wr = aw_pend && w_pend && !s_axi_bvalid;
  wire [31:0] wd = wdata_q;
  wire wr_cmd = do_wr && awaddr_q == cal_pkg::CAL_OFF_CMD && wstrb_q[0];
  wire wr_acc = do_wr && awaddr_q == cal_pkg::CAL_OFF_ACC && wstrb_q[0];
  wire wr_p0 = do_wr && awaddr_q == cal_pkg::CAL_OFF_PTR0;
  wire wr_p1 = do_wr && awaddr_q == cal_pkg::CAL_OFF_PTR1;
  wire wr_file = do_wr && awaddr_q == cal_pkg::CAL_OFF_FILE && wstrb_q[0];
  wire wr_hit = awaddr_q == cal_pkg::CAL_OFF_CMD || awaddr_q == cal_pkg::CAL_OFF_ACC ||
    awaddr_q == cal_pkg::CAL_OFF_PTR0 || awaddr_q == cal_pkg::CAL_OFF_PTR1 ||
    awaddr_q == cal_pkg::CAL_OFF_FILE || awaddr_q == cal_pkg::CAL_OFF_STAT;

  // Command fields
  wire [2:0] op = wd[cal_pkg::CAL_OP_LSB +: 3];
  wire [7:0] imm = wd[cal_pkg::CAL_IMM_LSB +: 8];
  wire [6:0] fa = wd[cal_pkg::CAL_ADDR_LSB +: 7];
  wire dest_f = wd[cal_pkg::CAL_DEST_BIT];
  wire psel = wd[cal_pkg::CAL_PSEL_BIT];
  wire [7:0] fv = file_q[fa];

  // Pointer add: sign-extended 6-bit immediate, 16-bit wrap
  wire [15:0] simm = {{10{imm[5]}}, imm[5:0]};
  wire [15:0] ptr_sum = ptr_q[psel] + simm;

  // Adder shared by add operations, nibble carry from bit 3
  wire [7:0] add_b = (op == cal_pkg::CAL_OP_ADD_IMM) ? imm : fv;
  wire add_ci = (op == cal_pkg::CAL_OP_ADDC_REG) ? c_q : 1'b0;
  wire [4:0] lo_sum = {1'b0, acc_q[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};
  wire [8:0] sum9 = {1'b0, acc_q} + {1'b0, add_b} + {8'h00, add_ci};

  // Operation result and flag updates
  logic [7:0] res;
  logic to_file;
  always_comb begin
    res = 8'h00;
    to_file = 1'b0;
    acc_d = acc_q;
    c_d = c_q;
    nib_d = nib_q;
    z_d = z_q;
    case (cal_pkg::cal_op_t'(op))
      cal_pkg::CAL_OP_AND_IMM: begin
        res = acc_q & imm;
        z_d = res == 8'h00;
      end
      cal_pkg::CAL_OP_ADD_IMM, cal_pkg::CAL_OP_ADD_REG, cal_pkg::CAL_OP_ADDC_REG: begin
        res = sum9[7:0];
        c_d = sum9[8];
        nib_d = lo_sum[4];
        z_d = res == 8'h00;
      end
      cal_pkg::CAL_OP_AND_REG: begin
        res = acc_q & fv;
        z_d = res == 8'h00;
      end
      cal_pkg::CAL_OP_ASR: begin
        res = {fv[7], fv[7:1]};
        c_d = fv[0];
        z_d = res == 8'h00;
      end
      default: res = acc_q;
    endcase
    if (op >= 3'(cal_pkg::CAL_OP_AND_REG)) begin
      to_file = dest_f;
    end
    if (op != 3'(cal_pkg::CAL_OP_NONE) && op != 3'(cal_pkg::CAL_OP_PTR_ADD) && !to_file) begin
      acc_d = res;
    end
  end

  // AXI write address/data capture, response; readies come from flops
  always_ff @(posedge clk_sys_in or negedge rstn_q) begin
    if (!rstn_q) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cal_pkg::CAL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? cal_pkg::CAL_RESP_OKAY : cal_pkg::CAL_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        // Both channels reopen only once the answer is taken
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Accumulator, flags and pointer pairs
  always_ff @(posedge clk_sys_in or negedge rstn_q) begin
    if (!rstn_q) begin
      acc_q <= cal_pkg::CAL_ACC_RST;
      {c_q, nib_q, z_q} <= 3'b000;
      ptr_q[0] <= cal_pkg::CAL_PTR_RST;
      ptr_q[1] <= cal_pkg::CAL_PTR_RST;
    end else if (wr_cmd) begin
      acc_q <= acc_d;
      {c_q, nib_q, z_q} <= {c_d, nib_d, z_d};
      if (op == 3'(cal_pkg::CAL_OP_PTR_ADD)) begin
        ptr_q[psel] <= ptr_sum;
      end
    end else if (wr_acc) begin
      acc_q <= wd[7:0];
    end else if (wr_p0 || wr_p1) begin
      ptr_q[wr_p1] <= wd[15:0];
    end
  end

  // File registers: written back by operations or loaded directly
  always_ff @(posedge clk_sys_in) begin
    if (wr_cmd && to_file) begin
      file_q[fa] <= res;
    end else if (wr_file) begin
      file_q[wd[cal_pkg::CAL_FADDR_LSB +: 7]] <= wd[7:0];
    end
  end

  // AXI read channel, one cycle after address taken
  logic [31:0] rmux;
  always_comb begin
    case (s_axi_araddr)
      cal_pkg::CAL_OFF_ACC: rmux = {24'h00_0000, acc_q};
      cal_pkg::CAL_OFF_STAT: rmux = {29'h0, z_q, nib_q, c_q};
      cal_pkg::CAL_OFF_PTR0: rmux = {16'h0000, ptr_q[0]};
      cal_pkg::CAL_OFF_PTR1: rmux = {16'h0000, ptr_q[1]};
      default: rmux = 32'h0000_0000;
    endcase
  end
  wire rd_hit = s_axi_araddr == cal_pkg::CAL_OFF_ACC || s_axi_araddr == cal_pkg::CAL_OFF_STAT ||
    s_axi_araddr == cal_pkg::CAL_OFF_PTR0 || s_axi_araddr == cal_pkg::CAL_OFF_PTR1 ||
    s_axi_araddr == cal_pkg::CAL_OFF_CMD || s_axi_araddr == cal_pkg::CAL_OFF_FILE;
  always_ff @(posedge clk_sys_in or negedge rstn_q) begin
    if (!rstn_q) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cal_pkg::CAL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rmux;
      s_axi_rresp <= rd_hit ? cal_pkg::CAL_RESP_OKAY : cal_pkg::CAL_RESP_SLVERR;
    end else if (s_axi_rready) begin
      // Next address is taken only after the data has gone
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Visible state outputs
  always_ff @(posedge clk_sys_in or negedge rstn_q) begin
    if (!rstn_q) begin
      acc_out <= cal_pkg::CAL_ACC_RST;
      flags_out <= 3'b000;
    end else begin
      acc_out <= acc_q;
      flags_out <= {z_q, nib_q, c_q};
    end
  end
endmodule

// file: tb/cal_core_assertions.sv
// Checker for command results and bus answers of the datapath.
// Assumes: bound into cal_core; a command shows at acc_out one cycle after its answer.
`timescale 1ns/1ps
module cal_core_chk (
  input wire logic clk_sys_in, rstn_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [7:0] s_axi_awaddr, acc_out,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [2:0] flags_out
);
  logic [7:0] aw_q;
  logic [31:0] w_q;
  // Last address and command word taken
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_q <= 8'h00;
      w_q <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // Answer to a command word
  sequence s_done;
    $rose(s_axi_bvalid) && aw_q == cal_pkg::CAL_OFF_CMD;
  endsequence
  property p_and_imm;
    s_done ##0 w_q[2:0] == 3'h2 |=> acc_out == ($past(acc_out) & w_q[15:8]) &&
      flags_out[1:0] == $past(flags_out[1:0]);
  endproperty
  a_and_imm: assert property (p_and_imm) else $error("and immediate result");
  property p_add_imm;
    s_done ##0 w_q[2:0] == 3'h3 |=> {flags_out[0], acc_out} == {1'b0, $past(acc_out)} + w_q[15:8];
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("add immediate result");
  property p_ptr;
    s_done ##0 w_q[2:0] == 3'h1 |=> $stable(flags_out) && $stable(acc_out);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer add touched flags");
  property p_asr;
    s_done ##0 w_q[2:0] == 3'h6 && !w_q[23] |=> acc_out[7] == acc_out[6];
  endproperty
  a_asr: assert property (p_asr) else $error("shift lost top bit");
  property p_dest;
    s_done ##0 w_q[2] && w_q[23] |=> $stable(acc_out);
  endproperty
  a_dest: assert property (p_dest) else $error("register target changed acc");
  property p_zero;
    s_done ##0 w_q[2:0] > 3'h1 && !w_q[23] |=> flags_out[2] == (acc_out == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
endmodule
bind cal_core cal_core_chk chk_i (
  .clk_sys_in(clk_sys_in),
  .rstn_in(rstn_in),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_awaddr(s_axi_awaddr),
  .acc_out(acc_out),
  .s_axi_wdata(s_axi_wdata),
  .flags_out(flags_out)
);

// file: tb/cal_axi_master.sv
// Register-bus master model standing in for the instruction decoder.
// Assumes: tasks are entered just after a rising edge; answers are always accepted.
`timescale 1ns/1ps
module cal_axi_master (
  input wire logic clk_sys_in, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  output logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0,
  output logic s_axi_bready = 1'b1, s_axi_rready = 1'b1,
  output logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00,
  output logic [31:0] s_axi_wdata = 32'h0,
  output logic [3:0] s_axi_wstrb = 4'hF
);
  // Write: both channels offered, each released with inverted payload once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  // Read: address held until taken, data taken at the answer edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule

// file: tb/cal_core_tb.sv
// Self-checking bench: commands and register reads over the register bus.
// Assumes: the master model makes every bus transfer; one 25 MHz clock.
`timescale 1ns/1ps
module cal_core_tb;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, acc_out;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] flags_out;
  int n_mismatch = 0;
  int compares = 0;
  cal_core dut (.*);
  cal_axi_master m (.*);
  always #20 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wok(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    m.wr(a, d, r);
    chk(32'(r), 32'(e));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    m.rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(cal_pkg::CAL_RESP_OKAY));
  endtask
  // Reset values, unmapped places
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rchk(cal_pkg::CAL_OFF_ACC, 32'h0);
    rchk(cal_pkg::CAL_OFF_PTR1, 32'h0);
    rchk(cal_pkg::CAL_OFF_STAT, 32'h0);
    wok(8'h20, 32'h0, cal_pkg::CAL_RESP_SLVERR);
    m.rd(8'h20, d, r);
    chk(32'(r), 32'(cal_pkg::CAL_RESP_SLVERR));
    chk(d, 32'h0);
    $display("test reset done");
  endtask
  // Rows: start acc, op, imm or cmd, expected acc, expected status
  task automatic t_ops;
    logic [39:0] ti [5] = '{40'hF0_03_15_05_01, 40'hAC_02_53_00_05, 40'h0F_03_01_10_02,
      40'hF3_02_3C_30_02, 40'hFF_03_01_00_07};
    logic [55:0] tr [5] = '{56'h00FF0005_0F_0F_02, 56'h007F0004_0F_00_06,
      56'h007F0007_70_00_05, 56'h007F0007_00_91_00, 56'h00030006_00_C0_01};
    foreach (ti[i]) begin
      wok(cal_pkg::CAL_OFF_ACC, {24'h0, ti[i][39:32]}, 2'b00);
      wok(cal_pkg::CAL_OFF_CMD, {16'h0, ti[i][23:16], 5'h0, ti[i][26:24]}, 2'b00);
      rchk(cal_pkg::CAL_OFF_ACC, {24'h0, ti[i][15:8]});
      rchk(cal_pkg::CAL_OFF_STAT, {24'h0, ti[i][7:0]});
    end
    wok(cal_pkg::CAL_OFF_FILE, 32'h7F81, 2'b00);
    wok(cal_pkg::CAL_OFF_FILE, 32'h0381, 2'b00);
    foreach (tr[i]) begin
      wok(cal_pkg::CAL_OFF_ACC, {24'h0, tr[i][23:16]}, 2'b00);
      wok(cal_pkg::CAL_OFF_CMD, tr[i][55:24], 2'b00);
      rchk(cal_pkg::CAL_OFF_ACC, {24'h0, tr[i][15:8]});
      rchk(cal_pkg::CAL_OFF_STAT, {24'h0, tr[i][7:0]});
    end
    $display("test operations done");
  endtask
  // Pointer adds at both wrap ends and both range ends
  task automatic t_ptr;
    wok(cal_pkg::CAL_OFF_PTR0, 32'hFFFE, 2'b00);
    wok(cal_pkg::CAL_OFF_PTR1, 32'h0010, 2'b00);
    wok(cal_pkg::CAL_OFF_CMD, 32'h0000_0501, 2'b00);
    rchk(cal_pkg::CAL_OFF_PTR0, 32'h0003);
    wok(cal_pkg::CAL_OFF_CMD, 32'h0100_2001, 2'b00);
    rchk(cal_pkg::CAL_OFF_PTR1, 32'hFFF0);
    wok(cal_pkg::CAL_OFF_CMD, 32'h0100_1F01, 2'b00);
    rchk(cal_pkg::CAL_OFF_PTR1, 32'h000F);
    rchk(cal_pkg::CAL_OFF_PTR0, 32'h0003);
    chk({21'h0, flags_out, acc_out}, 32'h01C0);
    $display("test pointer done");
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    t_reset;
    t_ops;
    t_ptr;
    complete_run;
  end
  // Watchdog well past the 150 or so cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    n_mismatch++;
    complete_run;
  end
endmodule
